//--- hdl/data_addr_unit.sv
// Data memory address formation, bank decoding and bank pointer.
// Assumes the decode logic on the same clock presents instructions in Q1
// and the ALU result in Q4; special registers other than the bank pointer live outside this block.
`timescale 1ns/10ps
`default_nettype none
`include "data_mem_defs.svh"
module data_addr_unit (
    input wire logic clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire data_mem_pkg::op_kind_t op_kind,
    input wire logic access_sel,
    input wire logic [7:0] offset,
    input wire logic [11:0] full_src,
    input wire logic [11:0] full_dst,
    input wire logic [7:0] literal,
    input wire logic dest_write,
    input wire logic [7:0] alu_result,
    input wire logic extended_set_enable,
    input wire logic [11:0] ext_map_addr,
    input wire logic [7:0] sfr_rd_data,
    output data_mem_pkg::q_phase_t phase,
    output logic [11:0] data_addr,
    output logic [7:0] operand_data,
    output logic status_update,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic [7:0] sfr_wdata,
    output logic pc_low_write,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    // ======================================================================
    // Helpers
    function automatic logic [11:0] map_addr(input logic a, input logic [7:0] ofs,
                                             input logic [3:0] bank, input logic ext,
                                             input logic [11:0] ext_addr);
        if (a) begin
            map_addr = {bank, ofs};
        end else if (ext) begin
            map_addr = ext_addr;
        end else if (ofs < `ACCESS_SPLIT) begin
            map_addr = {`ACCESS_LO_BANK, ofs};
        end else begin
            map_addr = {`ACCESS_HI_BANK, ofs};
        end
    endfunction : map_addr

    function automatic data_mem_pkg::region_t region_of(input logic [11:0] addr);
        if (addr[11:8] == `GPR_BANK) begin
            region_of = data_mem_pkg::RG_GPR;
        end else if (addr == `BANK_PTR_ADDR) begin
            region_of = data_mem_pkg::RG_BANK_PTR;
        end else if (addr >= `SFR_BASE) begin
            region_of = data_mem_pkg::RG_SFR;
        end else begin
            region_of = data_mem_pkg::RG_NONE;
        end
    endfunction : region_of

    // ======================================================================
    // State
    data_mem_pkg::q_phase_t phase_ff, nxt_phase;
    data_mem_pkg::op_kind_t kind_ff, nxt_kind;
    logic [11:0] src_ff, nxt_src;
    logic [11:0] dst_ff, nxt_dst;
    logic [3:0] lit_ff, nxt_lit;
    logic wr_ff, nxt_wr;
    logic [3:0] bank_ptr_ff, nxt_bank_ptr;
    logic [7:0] sfr_cap_ff, nxt_sfr_cap;
    logic [7:0] operand_ff, nxt_operand;
    logic [7:0] reg_rdata_ff, nxt_reg_rdata;
    logic [11:0] last_addr_ff, nxt_last_addr;
    logic last_unimpl_ff, nxt_last_unimpl;
    logic [7:0] ram_rd_data;
    logic [7:0] wdata;
    logic [7:0] read_mux;
    data_mem_pkg::region_t src_rg, dst_rg;
    logic dst_active;

    assign src_rg = region_of(src_ff);
    assign dst_rg = region_of(dst_ff);
    assign dst_active = (phase_ff == data_mem_pkg::PH_Q4) && wr_ff;
    assign wdata = (kind_ff == data_mem_pkg::OP_FULL_MOVE) ? operand_ff : alu_result;

    // ======================================================================
    // Phase sequencer and instruction capture
    always_comb begin
        nxt_phase = phase_ff;
        unique case (phase_ff)
            data_mem_pkg::PH_Q1: nxt_phase = data_mem_pkg::PH_Q2;
            data_mem_pkg::PH_Q2: nxt_phase = data_mem_pkg::PH_Q3;
            data_mem_pkg::PH_Q3: nxt_phase = data_mem_pkg::PH_Q4;
            data_mem_pkg::PH_Q4: nxt_phase = data_mem_pkg::PH_Q1;
        endcase
        nxt_kind = kind_ff;
        nxt_src = src_ff;
        nxt_dst = dst_ff;
        nxt_lit = lit_ff;
        nxt_wr = wr_ff;
        if (phase_ff == data_mem_pkg::PH_Q1) begin
            nxt_kind = instr_valid ? op_kind : data_mem_pkg::OP_NONE;
            nxt_lit = literal[3:0];
            nxt_wr = 1'b0;
            if (instr_valid && op_kind == data_mem_pkg::OP_FULL_MOVE) begin
                nxt_src = full_src;
                nxt_dst = full_dst;
                nxt_wr = 1'b1;
            end else if (instr_valid && op_kind == data_mem_pkg::OP_FILE) begin
                nxt_src = map_addr(access_sel, offset, bank_ptr_ff,
                                   extended_set_enable, ext_map_addr);
                nxt_dst = nxt_src;
                nxt_wr = dest_write;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_ff <= data_mem_pkg::PH_Q1;
            kind_ff <= data_mem_pkg::OP_NONE;
            src_ff <= 12'h000;
            dst_ff <= 12'h000;
            lit_ff <= 4'h0;
            wr_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            kind_ff <= nxt_kind;
            src_ff <= nxt_src;
            dst_ff <= nxt_dst;
            lit_ff <= nxt_lit;
            wr_ff <= nxt_wr;
        end
    end

    // ======================================================================
    // Implemented bank
    // only bank 0 stored, others dropped
    data_bank_ram u_bank0 (
        .clk(clk),
        .rd_en(phase_ff == data_mem_pkg::PH_Q2 && src_rg == data_mem_pkg::RG_GPR),
        .rd_addr(src_ff[7:0]),
        .wr_en(dst_active && dst_rg == data_mem_pkg::RG_GPR),
        .wr_addr(dst_ff[7:0]),
        .wr_data(wdata),
        .rd_data_ff(ram_rd_data)
    );

    // ======================================================================
    // Operand read and bank pointer
    always_comb begin
        unique case (src_rg)
            data_mem_pkg::RG_GPR: read_mux = ram_rd_data;
            data_mem_pkg::RG_SFR: read_mux = sfr_cap_ff;
            data_mem_pkg::RG_BANK_PTR: read_mux = {4'h0, bank_ptr_ff};
            data_mem_pkg::RG_NONE: read_mux = 8'h00;
        endcase
        nxt_sfr_cap = sfr_cap_ff;
        nxt_operand = operand_ff;
        nxt_last_addr = last_addr_ff;
        nxt_last_unimpl = last_unimpl_ff;
        if (phase_ff == data_mem_pkg::PH_Q2) begin
            nxt_sfr_cap = sfr_rd_data;
        end
        if (phase_ff == data_mem_pkg::PH_Q3 && kind_ff != data_mem_pkg::OP_NONE) begin
            nxt_operand = read_mux;
            nxt_last_addr = src_ff;
            nxt_last_unimpl = (src_rg == data_mem_pkg::RG_NONE);
        end
        nxt_bank_ptr = bank_ptr_ff;
        if (reg_wr && reg_addr == `REG_BANK_PTR) begin
            nxt_bank_ptr = reg_wdata[3:0];
        end
        if (phase_ff == data_mem_pkg::PH_Q4 && kind_ff == data_mem_pkg::OP_LOAD_BANK) begin
            nxt_bank_ptr = lit_ff;
        end else if (dst_active && dst_rg == data_mem_pkg::RG_BANK_PTR) begin
            nxt_bank_ptr = wdata[3:0];
        end
        nxt_reg_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `REG_BANK_PTR: nxt_reg_rdata = {4'h0, bank_ptr_ff};
                `REG_LAST_LO: nxt_reg_rdata = last_addr_ff[7:0];
                `REG_LAST_HI: nxt_reg_rdata = {3'b000, last_unimpl_ff, last_addr_ff[11:8]};
                default: nxt_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bank_ptr_ff <= `BANK_PTR_RST;
            sfr_cap_ff <= 8'h00;
            operand_ff <= 8'h00;
            reg_rdata_ff <= 8'h00;
            last_addr_ff <= 12'h000;
            last_unimpl_ff <= 1'b0;
        end else begin
            bank_ptr_ff <= nxt_bank_ptr;
            sfr_cap_ff <= nxt_sfr_cap;
            operand_ff <= nxt_operand;
            reg_rdata_ff <= nxt_reg_rdata;
            last_addr_ff <= nxt_last_addr;
            last_unimpl_ff <= nxt_last_unimpl;
        end
    end

    // ======================================================================
    // Outputs
    assign phase = phase_ff;
    assign data_addr = (phase_ff == data_mem_pkg::PH_Q4) ? dst_ff : src_ff;
    assign operand_data = operand_ff;
    assign reg_rdata = reg_rdata_ff;
    assign sfr_wdata = wdata;
    assign sfr_rd = (phase_ff == data_mem_pkg::PH_Q2) && (kind_ff != data_mem_pkg::OP_NONE)
                    && (src_rg == data_mem_pkg::RG_SFR);
    assign sfr_wr = dst_active && (dst_rg == data_mem_pkg::RG_SFR);
    assign pc_low_write = sfr_wr && (dst_ff == `PC_LOW_ADDR);
    // flags every file op, one cycle
    assign status_update = (phase_ff == data_mem_pkg::PH_Q4) && (kind_ff == data_mem_pkg::OP_FILE);

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_file_banked;
        phase_ff == data_mem_pkg::PH_Q1 && instr_valid
            && op_kind == data_mem_pkg::OP_FILE && access_sel;
    endsequence
    sequence s_file_fast;
        phase_ff == data_mem_pkg::PH_Q1 && instr_valid && op_kind == data_mem_pkg::OP_FILE
            && !access_sel && !extended_set_enable;
    endsequence
    sequence s_pc_low_target;
        phase_ff == data_mem_pkg::PH_Q1 && instr_valid && op_kind == data_mem_pkg::OP_FILE
            && access_sel && bank_ptr_ff == 4'hF && offset == 8'hF9 && dest_write;
    endsequence

    a_phase_order: assert property (
        phase_ff == data_mem_pkg::PH_Q1 |=> phase_ff == data_mem_pkg::PH_Q2 ##1
        phase_ff == data_mem_pkg::PH_Q3 ##1 phase_ff == data_mem_pkg::PH_Q4)
        else $error("phase order broken");
    a_banked_addr: assert property (
        s_file_banked |=> src_ff == {$past(bank_ptr_ff), $past(offset)})
        else $error("banked address wrong");
    a_fast_map: assert property (
        s_file_fast |=> src_ff == {($past(offset) < 8'h80) ? 4'h0 : 4'hF, $past(offset)})
        else $error("fast map address wrong");
    a_full_move: assert property (
        phase_ff == data_mem_pkg::PH_Q1 && instr_valid && op_kind == data_mem_pkg::OP_FULL_MOVE
        |=> src_ff == $past(full_src) && dst_ff == $past(full_dst))
        else $error("full move address wrong");
    a_unimpl_zero: assert property (
        phase_ff == data_mem_pkg::PH_Q3 && kind_ff != data_mem_pkg::OP_NONE
        && src_rg == data_mem_pkg::RG_NONE |=> operand_ff == 8'h00)
        else $error("unimplemented read not zero");
    a_flags_q4: assert property (
        s_file_banked |=> ##2 status_update ##1 !status_update)
        else $error("status update missing");
    a_pc_low_hit: assert property (
        s_pc_low_target |=> ##2 pc_low_write)
        else $error("program counter low write missing");
    a_load_bank: assert property (
        phase_ff == data_mem_pkg::PH_Q1 && instr_valid && op_kind == data_mem_pkg::OP_LOAD_BANK
        |=> ##3 bank_ptr_ff == $past(literal[3:0], 4))
        else $error("bank literal not loaded");
    a_bank_upper: assert property (
        reg_rd && reg_addr == `REG_BANK_PTR |=> reg_rdata[7:4] == 4'h0
        && reg_rdata[3:0] == $past(bank_ptr_ff))
        else $error("bank pointer read wrong");
    a_reset_bank: assert property (
        $fell(reset) |-> bank_ptr_ff == 4'h0)
        else $error("bank pointer not cleared");
endmodule : data_addr_unit
`default_nettype wire

//--- hdl/data_mem_defs.svh
// Constants for data memory address formation and bank decoding.
// Assumes inclusion by the address unit only.
`ifndef DATA_MEM_DEFS_SVH
`define DATA_MEM_DEFS_SVH

// ==========================================================================
// Address map
`define ACCESS_SPLIT 8'h80
`define ACCESS_LO_BANK 4'h0
`define ACCESS_HI_BANK 4'hF
`define GPR_BANK 4'h0
`define SFR_BASE 12'hF80
`define BANK_PTR_ADDR 12'hFE0
`define PC_LOW_ADDR 12'hFF9

// ==========================================================================
// Reset values
`define BANK_PTR_RST 4'h0

// ==========================================================================
// Register port offsets and fields
`define REG_BANK_PTR 4'h0
`define REG_LAST_LO 4'h1
`define REG_LAST_HI 4'h2
`define LAST_HI_UNIMPL 4

`endif

//--- hdl/data_mem_pkg.sv
// Types shared by the address unit, the decode model and the bench.
// Assumes nothing of its surroundings.
package data_mem_pkg;
    // ======================================================================
    // Quadrature phase of an instruction cycle
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} q_phase_t;
    // ======================================================================
    // Instruction classes seen by this block
    typedef enum logic [1:0] {OP_NONE, OP_FILE, OP_FULL_MOVE, OP_LOAD_BANK} op_kind_t;
    // ======================================================================
    // Region decoded from a full data address
    typedef enum logic [1:0] {RG_GPR, RG_SFR, RG_BANK_PTR, RG_NONE} region_t;
endpackage : data_mem_pkg

//--- hdl/data_bank_ram.sv
// The one implemented bank of general purpose storage, 256 bytes.
// Assumes one clock; read data come out of a register one cycle later.
`timescale 1ns/10ps
`default_nettype none
module data_bank_ram (
    input wire logic clk,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data_ff
);
    logic [7:0] mem [0:255];
    logic [7:0] nxt_rd_data;

    // ======================================================================
    // Read path
    always_comb begin
        nxt_rd_data = rd_en ? mem[rd_addr] : rd_data_ff;
    end

    always_ff @(posedge clk) begin
        rd_data_ff <= nxt_rd_data;
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule : data_bank_ram
`default_nettype wire

//--- dv/decode_model.sv
// Model of the decode pipeline and outside registers feeding the address unit.
// Assumes one clock shared with the address unit; the bench calls issue.
`timescale 1ns/10ps
`default_nettype none
module decode_model (
    input wire logic clk,
    input wire data_mem_pkg::q_phase_t phase,
    input wire logic [11:0] data_addr,
    input wire logic sfr_rd,
    output var logic instr_valid,
    output var data_mem_pkg::op_kind_t op_kind,
    output var logic access_sel,
    output var logic [7:0] offset,
    output var logic [11:0] full_src,
    output var logic [11:0] full_dst,
    output var logic [7:0] literal,
    output var logic dest_write,
    output var logic [7:0] alu_result,
    output var logic [7:0] sfr_rd_data
);
    logic [7:0] noise_ff;
    // ======================================================================
    // Outside register read data, noise while not selected
    initial noise_ff = 8'h00;
    always @(posedge clk) noise_ff <= noise_ff + 8'h3B;
    assign sfr_rd_data = sfr_rd ? (data_addr[7:0] ^ 8'h5A) : noise_ff;
    // ======================================================================
    // Instruction offer, held over Q1, then scrambled
    initial begin
        {instr_valid, access_sel, dest_write} = 3'h0;
        op_kind = data_mem_pkg::OP_NONE;
        {offset, literal, alu_result} = 24'h0000_00;
        {full_src, full_dst} = 24'h0000_00;
    end
    task automatic issue(input data_mem_pkg::op_kind_t k, input logic a, input logic [7:0] o,
            input logic [11:0] s, input logic [11:0] d, input logic [7:0] lit,
            input logic dw, input logic [7:0] alu);
        @(negedge clk);
        while (phase !== data_mem_pkg::PH_Q4) @(negedge clk);
        @(posedge clk);
        instr_valid <= 1'b1;
        op_kind <= k;
        access_sel <= a;
        offset <= o;
        full_src <= s;
        full_dst <= d;
        literal <= lit;
        dest_write <= dw;
        alu_result <= alu;
        @(posedge clk);
        instr_valid <= 1'b0;
        op_kind <= data_mem_pkg::OP_NONE;
        access_sel <= ~a;
        offset <= ~o;
        full_src <= ~s;
        full_dst <= ~d;
        literal <= ~lit;
        dest_write <= 1'b0;
    endtask : issue
endmodule : decode_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the data address unit and its register port.
// Assumes the decode model beside it offers instructions at Q1.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam data_mem_pkg::op_kind_t K_FILE = data_mem_pkg::OP_FILE;
    localparam data_mem_pkg::op_kind_t K_FULL = data_mem_pkg::OP_FULL_MOVE;
    localparam logic NO = 1'b0;
    localparam logic YES = 1'b1;
    logic clk, reset, instr_valid, access_sel, dest_write, extended_set_enable;
    logic status_update, sfr_rd, sfr_wr, pc_low_write, reg_wr, reg_rd;
    logic [7:0] offset, literal, alu_result, sfr_rd_data, operand_data, sfr_wdata;
    logic [7:0] reg_wdata, reg_rdata;
    logic [11:0] full_src, full_dst, ext_map_addr, data_addr;
    logic [3:0] reg_addr;
    data_mem_pkg::op_kind_t op_kind;
    data_mem_pkg::q_phase_t phase;
    int num_errors, tests_run, cycles;
    data_addr_unit data_addr_unit_i (.clk(clk), .reset(reset), .instr_valid(instr_valid),
        .op_kind(op_kind), .access_sel(access_sel), .offset(offset), .full_src(full_src),
        .full_dst(full_dst), .literal(literal), .dest_write(dest_write),
        .alu_result(alu_result), .extended_set_enable(extended_set_enable),
        .ext_map_addr(ext_map_addr), .sfr_rd_data(sfr_rd_data), .phase(phase),
        .data_addr(data_addr), .operand_data(operand_data), .status_update(status_update),
        .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .pc_low_write(pc_low_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    decode_model decode_model_i (.clk(clk), .phase(phase), .data_addr(data_addr),
        .sfr_rd(sfr_rd), .instr_valid(instr_valid), .op_kind(op_kind),
        .access_sel(access_sel), .offset(offset), .full_src(full_src), .full_dst(full_dst),
        .literal(literal), .dest_write(dest_write), .alu_result(alu_result),
        .sfr_rd_data(sfr_rd_data));
    // ======================================================================
    // Clock and timeout
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            wrap_up();
        end
    end
    // ======================================================================
    // Compare, bus and instruction tasks
    task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check_val({4'h0, reg_rdata}, {4'h0, e});
    endtask : reg_read
    task automatic load_bank(input logic [7:0] lit);
        decode_model_i.issue(data_mem_pkg::OP_LOAD_BANK, 1'b0, 8'h00, 12'h000, 12'h000,
            lit, 1'b0, 8'h00);
        repeat (3) @(posedge clk);
    endtask : load_bank
    // Operand skipped when op[8] set; file ops give s for d
    task automatic instr(input data_mem_pkg::op_kind_t k, input logic a, input logic [7:0] o,
            input logic [11:0] s, input logic [11:0] d, input logic dw, input logic [7:0] alu,
            input logic rd, input logic [8:0] op, input logic wr, input logic pc);
        decode_model_i.issue(k, a, o, s, d, 8'h00, dw, alu);
        @(negedge clk);
        check_val({10'h000, phase}, {10'h000, data_mem_pkg::PH_Q2});
        check_val(data_addr, s);
        check_bit(sfr_rd, rd);
        repeat (2) @(negedge clk);
        check_val({10'h000, phase}, {10'h000, data_mem_pkg::PH_Q4});
        if (!op[8]) check_val({4'h0, operand_data}, {4'h0, op[7:0]});
        check_val(data_addr, d);
        check_bit(status_update, k == K_FILE);
        check_bit(sfr_wr, wr);
        check_bit(pc_low_write, pc);
        if (wr) check_val({4'h0, sfr_wdata}, {4'h0, (k == K_FULL) ? op[7:0] : alu});
    endtask : instr
    task automatic wrap_up;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    // ======================================================================
    // Main sequence
    initial begin
        num_errors = 0;
        tests_run = 0;
        cycles = 0;
        reset = 1'b1;
        {reg_wr, reg_rd, extended_set_enable} = 3'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        ext_map_addr = 12'h000;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        reg_read(4'h0, 8'h00);
        reg_write(4'h0, 8'hFF);
        reg_read(4'h0, 8'h0F);
        reg_read(4'h3, 8'h00);
        load_bank(8'hA3);
        reg_read(4'h0, 8'h03);
        instr(K_FILE, NO, 8'h12, 12'h012, 12'h012, YES, 8'h3C, NO, 9'h100, NO, NO);
        instr(K_FILE, YES, 8'h12, 12'h312, 12'h312, YES, 8'h77, NO, 9'h000, NO, NO);
        reg_read(4'h2, 8'h13);
        reg_read(4'h1, 8'h12);
        instr(K_FILE, YES, 8'h12, 12'h312, 12'h312, NO, 8'h00, NO, 9'h000, NO, NO);
        instr(K_FILE, NO, 8'h12, 12'h012, 12'h012, NO, 8'h00, NO, 9'h03C, NO, NO);
        instr(K_FILE, NO, 8'h85, 12'hF85, 12'hF85, NO, 8'h00, YES, 9'h0DF, NO, NO);
        reg_write(4'h0, 8'h0F);
        instr(K_FILE, YES, 8'hF9, 12'hFF9, 12'hFF9, YES, 8'h11, YES, 9'h0A3, YES, YES);
        instr(K_FILE, YES, 8'h10, 12'hF10, 12'hF10, NO, 8'h00, NO, 9'h000, NO, NO);
        instr(K_FULL, NO, 8'h00, 12'h012, 12'hF85, NO, 8'h00, NO, 9'h03C, YES, NO);
        reg_write(4'h0, 8'h00);
        instr(K_FILE, YES, 8'hFF, 12'h0FF, 12'h0FF, YES, 8'h5E, NO, 9'h100, NO, NO);
        instr(K_FILE, YES, 8'hFF, 12'h0FF, 12'h0FF, NO, 8'h00, NO, 9'h05E, NO, NO);
        instr(K_FILE, NO, 8'hE0, 12'hFE0, 12'hFE0, YES, 8'hA5, NO, 9'h000, NO, NO);
        reg_read(4'h0, 8'h05);
        @(posedge clk);
        extended_set_enable <= 1'b1;
        ext_map_addr <= 12'h034;
        instr(K_FILE, NO, 8'h12, 12'h034, 12'h034, NO, 8'h00, NO, 9'h100, NO, NO);
        @(posedge clk);
        extended_set_enable <= 1'b0;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
